// [hdl/dimgw_ctrl.sv]
// Display image window controller with AHB-Lite register slave
//
// Contract
// - Field 1 pixels stop at programmed width
// - Blank remainder of line after image
// - Field 1 lines stop at programmed height
// - Blank remaining active lines of field
// - Field 1 width even except raw
// - Field 2 line counter loads at offset
// - Negative vertical offset subtracts from blank end
// - Field 2 image begins at counter one
// - Pixel counter cleared at image start
// - Field 2 pixels start at horizontal offset
// - Negative horizontal start is width minus offset
// - Blank pixels before horizontal offset
// - Field 2 horizontal offset even except raw
// - Negative vertical bit ignored in raw
// - Negative horizontal bit ignored in raw
// - Reserved bits read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none

module dimgw_ctrl
    import dimgw_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Frame timing, same clock domain
    input wire dimgw_timing_t timing_in,
    // Pixel stream
    input wire logic [9:0] fifo_data_in,
    input wire logic [9:0] blank_data_in,
    output logic fifo_rd_out,
    output logic [9:0] pixel_out,
    output logic image_out
);

    dimgw_state_t s;
    dimgw_state_t next_s;

    // Decoded settings
    logic mode_raw;
    logic [11:0] width1;
    logic [11:0] height1;
    logic [11:0] hoff2;
    logic [11:0] voff2;
    logic neg_v;
    logic neg_h;

    // Window control terms
    logic line_start;
    logic field_change;
    logic [11:0] v2_line;
    logic [11:0] v_load_line;
    logic v_load;
    logic v_step;
    logic [11:0] v_limit;
    logic [11:0] h_start_px;
    logic h_start;
    logic [11:0] h_limit;

    // Counter outputs
    logic [11:0] image_line_counter;
    logic [11:0] image_pixel_counter;
    logic line_on;
    logic line_on_next;
    logic pix_on;

    // Bus decode
    logic ap_take;
    logic [31:0] read_word;

    // Settings after mode-dependent forcing
    always_comb
    begin
        mode_raw = (s.mode == DIMGW_MODE_RAW);
        width1 = s.field1_image_size[DIMGW_HFLD_MSB:DIMGW_HFLD_LSB];
        if (!mode_raw)
        begin
            width1[0] = 1'b0;
        end
        height1 = s.field1_image_size[DIMGW_VFLD_MSB:DIMGW_VFLD_LSB];
        hoff2 = s.field2_image_offset[DIMGW_HFLD_MSB:DIMGW_HFLD_LSB];
        if (!mode_raw)
        begin
            hoff2[0] = 1'b0;
        end
        voff2 = s.field2_image_offset[DIMGW_VFLD_MSB:DIMGW_VFLD_LSB];
        neg_v = s.field2_image_offset[DIMGW_NV_BIT] & ~mode_raw;
        neg_h = s.field2_image_offset[DIMGW_NH_BIT] & ~mode_raw;
    end

    // Vertical window: line counter load, step and limit per field
    always_comb
    begin
        line_start = (timing_in.frame_pixel_counter == 12'h000);
        field_change = (timing_in.field2 != s.field2_q);
        // Offset assumed not above blank end when negative
        if (neg_v)
        begin
            v2_line = timing_in.field2_vblank_end_line - voff2;
        end
        else
        begin
            v2_line = timing_in.field2_vblank_end_line + voff2;
        end
        if (timing_in.field2)
        begin
            v_load_line = v2_line;
            v_limit = timing_in.field2_image_height;
        end
        else
        begin
            v_load_line = timing_in.field1_first_line;
            v_limit = height1;
        end
        v_load = line_start && (timing_in.frame_line_counter == v_load_line);
        v_step = line_start && !v_load;
    end

    // Horizontal window: start pixel and width per field
    always_comb
    begin
        if (timing_in.field2)
        begin
            if (neg_h)
            begin
                h_start_px = timing_in.frame_width_pixels - hoff2;
            end
            else
            begin
                h_start_px = hoff2;
            end
            h_limit = timing_in.field2_image_width;
        end
        else
        begin
            h_start_px = timing_in.field1_first_pixel;
            h_limit = width1;
        end
        // Only lines inside the vertical window start an image span
        h_start = line_on_next && (timing_in.frame_pixel_counter == h_start_px);
    end

    // Image line counter, loaded with one on the first image line
    dimgw_span #(
        .START_VAL(DIMGW_LINE_START),
        .STOP_AHEAD(1'b0)
    ) u_line (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(v_load),
        .step_in(v_step),
        .clear_in(field_change),
        .limit_in(v_limit),
        .count_out(image_line_counter),
        .on_out(line_on),
        .on_next_out(line_on_next)
    );

    // Image pixel counter, cleared at each image span start
    dimgw_span #(
        .START_VAL(DIMGW_PIX_START),
        .STOP_AHEAD(1'b1)
    ) u_pixel (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(h_start),
        .step_in(pix_on),
        .clear_in(line_start),
        .limit_in(h_limit),
        .count_out(image_pixel_counter),
        .on_out(pix_on),
        .on_next_out()
    );

    // Register read multiplexer over the updated values
    function automatic logic [31:0] dimgw_read(
        input dimgw_state_t st,
        input logic [3:0] addr,
        input logic [11:0] lcnt,
        input logic [11:0] pcnt,
        input logic hon,
        input logic von
    );
        logic [31:0] w;
        w = 32'h00000000;
        case (addr)
            DIMGW_ADDR_SIZE1: w = st.field1_image_size & DIMGW_MASK_SIZE1;
            DIMGW_ADDR_OFF2: w = st.field2_image_offset & DIMGW_MASK_OFF2;
            DIMGW_ADDR_CTRL: w = {30'h00000000, st.mode};
            DIMGW_ADDR_STAT:
            begin
                w[DIMGW_VFLD_MSB:DIMGW_VFLD_LSB] = lcnt;
                w[DIMGW_HFLD_MSB:DIMGW_HFLD_LSB] = pcnt;
                w[DIMGW_STAT_HON_BIT] = hon;
                w[DIMGW_STAT_VON_BIT] = von;
                w[DIMGW_STAT_FLD_BIT] = st.field2_q;
            end
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction

    // Next state: bus slave, registers and pixel output
    always_comb
    begin
        next_s = s;
        read_word = 32'h00000000;
        ap_take = hsel_in && htrans_in[1] && hready_in;

        // Data phase of a write: store writable bits only
        if (s.ap_valid && s.ap_write)
        begin
            case (s.ap_addr)
                DIMGW_ADDR_SIZE1:
                begin
                    next_s.field1_image_size = hwdata_in & DIMGW_MASK_SIZE1;
                end
                DIMGW_ADDR_OFF2:
                begin
                    next_s.field2_image_offset = hwdata_in & DIMGW_MASK_OFF2;
                end
                DIMGW_ADDR_CTRL:
                begin
                    next_s.mode = hwdata_in[1:0];
                end
                default:
                begin
                    next_s.mode = s.mode; // Unmapped writes are dropped
                end
            endcase
        end

        // Address phase: capture and prepare read data
        next_s.ap_valid = ap_take;
        if (ap_take)
        begin
            next_s.ap_write = hwrite_in;
            next_s.ap_addr = (haddr_in[31:4] == 28'h0000000) ? haddr_in[3:0] : 4'h3;
            if (!hwrite_in)
            begin
                read_word = dimgw_read(next_s, next_s.ap_addr, image_line_counter,
                    image_pixel_counter, pix_on, line_on);
                next_s.hrdata = read_word;
            end
        end

        // Field tracking for the counter clear
        next_s.field2_q = timing_in.field2;

        // Image pixels inside the window, blanking elsewhere
        if (pix_on)
        begin
            next_s.pixel = fifo_data_in;
            next_s.image = 1'b1;
        end
        else
        begin
            next_s.pixel = blank_data_in;
            next_s.image = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s.ap_valid <= 1'b0;
            s.ap_write <= 1'b0;
            s.ap_addr <= 4'h0;
            s.hrdata <= 32'h00000000;
            s.field1_image_size <= DIMGW_RST_SIZE1;
            s.field2_image_offset <= DIMGW_RST_OFF2;
            s.mode <= DIMGW_RST_MODE;
            s.field2_q <= 1'b0;
            s.pixel <= 10'h000;
            s.image <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Bus outputs: zero wait, always OKAY
    assign hrdata_out = s.hrdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    // Stream outputs
    assign fifo_rd_out = pix_on; // One FIFO word per image pixel
    assign pixel_out = s.pixel;
    assign image_out = s.image;

endmodule

`default_nettype wire

// [hdl/dimgw_span.sv]
// Span counter: starts, steps and stops at a programmed limit
`timescale 1ns/100ps
`default_nettype none

module dimgw_span
    import dimgw_pkg::*;
#(
    parameter logic [11:0] START_VAL = 12'h000,
    parameter bit STOP_AHEAD = 1'b0
)
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic start_in,
    input wire logic step_in,
    input wire logic clear_in,
    input wire logic [11:0] limit_in,
    // Counter state
    output logic [11:0] count_out,
    output logic on_out,
    output logic on_next_out
);

    dimgw_span_t s;
    dimgw_span_t next_s;
    logic stop_hit;
    logic [11:0] count_inc;

    // Next state: start wins over clear, clear over step
    always_comb
    begin
        next_s = s;
        count_inc = s.count + 12'h001;
        stop_hit = STOP_AHEAD ? (count_inc == limit_in) : (s.count == limit_in);
        if (start_in)
        begin
            next_s.count = START_VAL;
            next_s.on = (limit_in != 12'h000);
        end
        else if (clear_in)
        begin
            next_s.on = 1'b0;
        end
        else if (step_in && s.on)
        begin
            // Stop once the counter meets the limit
            next_s.on = ~stop_hit;
            if (STOP_AHEAD || !stop_hit)
            begin
                next_s.count = count_inc;
            end
        end
    end

    // State register
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs
    assign count_out = s.count;
    assign on_out = s.on;
    assign on_next_out = next_s.on; // Combinational look-ahead

endmodule

`default_nettype wire

// [inc/dimgw_pkg.sv]
// Shared constants and types for the display image window controller
`default_nettype none

package dimgw_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [3:0] DIMGW_ADDR_SIZE1 = 4'h0;
    localparam logic [3:0] DIMGW_ADDR_OFF2 = 4'h4;
    localparam logic [3:0] DIMGW_ADDR_CTRL = 4'h8;
    localparam logic [3:0] DIMGW_ADDR_STAT = 4'hC;

    // Writable bits per register, reserved bits stay zero
    localparam logic [31:0] DIMGW_MASK_SIZE1 = 32'h0FFF0FFF;
    localparam logic [31:0] DIMGW_MASK_OFF2 = 32'h8FFF8FFF;
    localparam logic [31:0] DIMGW_MASK_CTRL = 32'h00000003;

    // Reset values
    localparam logic [31:0] DIMGW_RST_SIZE1 = 32'h00000000;
    localparam logic [31:0] DIMGW_RST_OFF2 = 32'h00000000;
    localparam logic [1:0] DIMGW_RST_MODE = 2'h0;

    // Field positions in size and offset registers
    localparam int DIMGW_VFLD_LSB = 16;
    localparam int DIMGW_VFLD_MSB = 27;
    localparam int DIMGW_HFLD_LSB = 0;
    localparam int DIMGW_HFLD_MSB = 11;
    localparam int DIMGW_NV_BIT = 31;
    localparam int DIMGW_NH_BIT = 15;

    // Status register field positions
    localparam int DIMGW_STAT_HON_BIT = 31;
    localparam int DIMGW_STAT_VON_BIT = 30;
    localparam int DIMGW_STAT_FLD_BIT = 29;

    // Counter start values
    localparam logic [11:0] DIMGW_LINE_START = 12'h001;
    localparam logic [11:0] DIMGW_PIX_START = 12'h000;

    // Output modes
    typedef enum logic [1:0] {
        DIMGW_MODE_BT656 = 2'b00,
        DIMGW_MODE_YC = 2'b01,
        DIMGW_MODE_RAW = 2'b10
    } dimgw_mode_t;

    // Frame timing from the display timing generator
    typedef struct packed {
        logic [11:0] frame_line_counter;
        logic [11:0] frame_pixel_counter;
        logic field2;
        logic [11:0] field1_first_line;
        logic [11:0] field1_first_pixel;
        logic [11:0] field2_vblank_end_line;
        logic [11:0] frame_width_pixels;
        logic [11:0] field2_image_width;
        logic [11:0] field2_image_height;
    } dimgw_timing_t;

    // State of one span counter
    typedef struct packed {
        logic [11:0] count;
        logic on;
    } dimgw_span_t;

    // State of the top-level controller
    typedef struct packed {
        logic ap_valid;
        logic ap_write;
        logic [3:0] ap_addr;
        logic [31:0] hrdata;
        logic [31:0] field1_image_size;
        logic [31:0] field2_image_offset;
        logic [1:0] mode;
        logic field2_q;
        logic [9:0] pixel;
        logic image;
    } dimgw_state_t;

endpackage

`default_nettype wire

// [verif/dimgw_checker.sv]
// Assertion checker for the display image window controller
`timescale 1ns/100ps
`default_nettype none

module dimgw_checker
    import dimgw_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Register bus
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // Pixel stream
    input wire dimgw_timing_t timing_in,
    input wire logic [9:0] fifo_data_in,
    input wire logic [9:0] blank_data_in,
    input wire logic fifo_rd_out,
    input wire logic [9:0] pixel_out,
    input wire logic image_out
);
    logic rd_ap;

    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Read address phase taken by the slave
    assign rd_ap = hsel_in && htrans_in[1] && hready_in && !hwrite_in;

    // Read data outside the mask is zero
    property p_rd(logic hit, logic [31:0] m);
        rd_ap && hit |=> (hrdata_out & ~m) == 32'h00000000;
    endproperty

    a_rsvd_size: assert property (p_rd(haddr_in == 32'h0, DIMGW_MASK_SIZE1))
        else $error("size register reserved bits not zero");
    a_rsvd_offset: assert property (p_rd(haddr_in == 32'h4, DIMGW_MASK_OFF2))
        else $error("offset register reserved bits not zero");
    a_rsvd_ctrl: assert property (p_rd(haddr_in == 32'h8, DIMGW_MASK_CTRL))
        else $error("control register reserved bits not zero");
    a_unmapped_zero: assert property (p_rd(haddr_in[31:4] != 28'h0, 32'h0))
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!rd_ap |=> $stable(hrdata_out))
        else $error("read data changed without a read");
    a_ready_okay: assert property (hreadyout_out && !hresp_out)
        else $error("slave not ready or not okay");
    a_fifo_pixel: assert property (fifo_rd_out |=> image_out && pixel_out == $past(fifo_data_in))
        else $error("taken word not shown as image pixel");
    a_blank_fill: assert property (!fifo_rd_out |=> !image_out && pixel_out == $past(blank_data_in))
        else $error("blank value not shown outside image");

    // Main scenarios
    c_field1_img: cover property ($rose(image_out) && !timing_in.field2);
    c_field2_img: cover property ($rose(image_out) && timing_in.field2);
    c_unmapped: cover property (rd_ap && haddr_in == 32'h10);
endmodule

bind dimgw_ctrl dimgw_checker i_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .timing_in(timing_in), .fifo_data_in(fifo_data_in),
    .blank_data_in(blank_data_in), .fifo_rd_out(fifo_rd_out), .pixel_out(pixel_out),
    .image_out(image_out));

`default_nettype wire

// [verif/dimgw_sink.sv]
// Video sink and pixel source facing the image window controller
`timescale 1ns/100ps
`default_nettype none

module dimgw_sink
    import dimgw_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Pixel stream from the controller and frame pixel position
    input wire logic fifo_rd_in,
    input wire logic [9:0] pixel_in,
    input wire logic image_in,
    input wire logic [11:0] fpix_in,
    // Source word and line statistics
    output logic [9:0] fifo_data_out,
    output logic [11:0] line_cnt_out,
    output logic [11:0] first_pos_out,
    output logic [15:0] data_err_out
);
    logic [9:0] seq_rd;
    logic [9:0] seq_img;
    logic [11:0] cnt;

    // Word valid only while taken, inverse otherwise
    assign fifo_data_out = fifo_rd_in ? seq_rd : ~seq_rd;

    // Per-line image count, first position and order check
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            seq_rd <= 10'h000;
            seq_img <= 10'h000;
            cnt <= 12'h000;
            line_cnt_out <= 12'h000;
            first_pos_out <= 12'h000;
            data_err_out <= 16'h0000;
        end
        else
        begin
            if (fifo_rd_in)
                seq_rd <= seq_rd + 10'h001;
            if (fpix_in == 12'h000)
            begin
                line_cnt_out <= cnt;
                cnt <= 12'h000;
            end
            if (image_in)
            begin
                if (pixel_in !== seq_img)
                    data_err_out <= data_err_out + 16'h0001;
                seq_img <= seq_img + 10'h001;
                cnt <= cnt + 12'h001;
                if (cnt == 12'h000)
                    first_pos_out <= fpix_in;
            end
        end
    end
endmodule

`default_nettype wire

// [verif/display_image_window_ctrl_tb.sv]
// Self-checking testbench for the display image window controller
`timescale 1ns/100ps
`default_nettype none

module display_image_window_ctrl_tb;
    import dimgw_pkg::*;

    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic fifo_rd;
    logic image;
    logic [9:0] fifo_data;
    logic [9:0] pixel;
    logic [9:0] blank = 10'h000;
    logic [11:0] ln = 12'h000;
    logic [11:0] fp = 12'h000;
    logic [11:0] sink_cnt;
    logic [11:0] sink_pos;
    logic [15:0] sink_err;
    dimgw_timing_t tim;
    int miscompares = 0;
    int checks_done = 0;
    int h1 = 0, w1 = 0, md = 0, nv = 0, nh = 0, vo = 0, hoff = 0, w2 = 0, h2 = 0, fp1 = 4;

    always #20 mclk_in = ~mclk_in;

    // Frame of 40 lines by 64 pixels, field 2 from line 20, blank end line 24
    assign tim = '{ln, fp, ln >= 12'h014, 12'h002, 12'(fp1), 12'h018, 12'h040,
        12'(w2), 12'(h2)};

    dimgw_ctrl i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .timing_in(tim),
        .fifo_data_in(fifo_data), .blank_data_in(blank), .fifo_rd_out(fifo_rd),
        .pixel_out(pixel), .image_out(image));

    dimgw_sink i_sink (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .fifo_rd_in(fifo_rd),
        .pixel_in(pixel), .image_in(image), .fpix_in(fp), .fifo_data_out(fifo_data),
        .line_cnt_out(sink_cnt), .first_pos_out(sink_pos), .data_err_out(sink_err));

    // Expected image pixels on line x
    function automatic int exp_cnt(int x);
        int s;
        if (x < 20)
            return (x >= 2 && x < 2 + h1) ? (md == 2 ? w1 : w1 & ~1) : 0;
        s = (nv != 0 && md != 2) ? 24 - vo : 24 + vo;
        return (x >= s && x < s + h2) ? w2 : 0;
    endfunction

    // Expected frame pixel of the first shown image pixel
    function automatic int exp_pos(int x);
        int ho;
        ho = (md == 2) ? hoff : hoff & ~1;
        if (x < 20)
            return fp1 + 2;
        return ((nh != 0 && md != 2) ? 64 - ho : ho) + 2;
    endfunction

    task automatic check(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    // One AHB-Lite single transfer
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        @(posedge mclk_in);
        while (hready !== 1'b1) @(posedge mclk_in);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge mclk_in);
        while (hready !== 1'b1) @(posedge mclk_in);
        q = hrdata;
    endtask

    task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        bus(1'b0, a, 32'h0, q);
        check(q === (d & m), "register readback");
    endtask

    task report_and_stop;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Frame counters and random blanking value
    always @(posedge mclk_in)
    begin
        if (!sys_rst_in)
        begin
            blank <= 10'($urandom);
            fp <= (fp == 12'h03F) ? 12'h000 : fp + 12'h001;
            if (fp == 12'h03F)
                ln <= (ln == 12'h027) ? 12'h000 : ln + 12'h001;
        end
    end

    // Compare each finished line but the last of the frame with the window settings
    always @(posedge mclk_in)
    begin
        if (!sys_rst_in && fp == 12'h001 && ln != 12'h000)
        begin
            check(sink_cnt === 12'(exp_cnt(int'(ln) - 1)), "image count");
            if (exp_cnt(int'(ln) - 1) != 0)
                check(sink_pos === 12'(exp_pos(int'(ln) - 1)), "image start");
        end
    end

    // Register checks, then one random window per frame over all modes
    initial
    begin
        logic [31:0] q;
        void'($urandom(32'h68e21ac1));
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        for (int a = 0; a < 16; a += 4)
        begin
            bus(1'b0, 32'(a), 32'h0, q);
            check(q === 32'h0, "reset value");
        end
        wr_rd(32'h10, $urandom, 32'h0);
        for (int f = 0; f < 8; f++)
        begin
            do @(posedge mclk_in); while (!(ln == 12'h000 && fp == 12'h002));
            md = f % 4;
            h1 = (f == 0) ? 1 : $urandom_range(10);
            w1 = (f == 0) ? 1 : $urandom_range(20);
            fp1 = $urandom_range(20, 4);
            nv = $urandom_range(1);
            nh = $urandom_range(1);
            vo = $urandom_range(nv != 0 ? 3 : 8);
            hoff = $urandom_range(16, 8);
            w2 = $urandom_range(5, 1);
            h2 = $urandom_range(6);
            wr_rd(32'h0, {4'($urandom), 12'(h1), 4'($urandom), 12'(w1)}, DIMGW_MASK_SIZE1);
            wr_rd(32'h4, {1'(nv), 3'($urandom), 12'(vo), 1'(nh), 3'($urandom), 12'(hoff)},
                DIMGW_MASK_OFF2);
            wr_rd(32'h8, {30'($urandom), 2'(md)}, DIMGW_MASK_CTRL);
            bus(1'b0, 32'hC, 32'h0, q);
            check((q & 32'hF000F000) === 32'h0, "status idle on line zero");
        end
        do @(posedge mclk_in); while (!(ln == 12'h000 && fp == 12'h002));
        check(sink_err === 16'h0000, "image data order");
        report_and_stop;
    end

    // Watchdog against a hung bus or stream
    initial
    begin
        #2000000;
        miscompares++;
        report_and_stop;
    end
endmodule

`default_nettype wire
